// file: src/ddsdg_pkg.sv
// constants, types and state layout for the disk status and data gating block
package ddsdg_pkg;
  localparam int CLK_MHZ = 25;
  localparam int CW = 19;
  localparam int T_DESEL_US = 50;
  localparam int T_AUTO_MS = 2;
  localparam real T_REV_MS = 16.8;
  localparam int T_IDX_US = 128;
  localparam int T_DROP_NS = 500;
  localparam real T_LOW_MS = 10.0;
  localparam int T_RECAL_MS = 3;
  localparam int T_BLK_W_US = 20;
  localparam int T_BLK_S_US = 100;
  localparam int DESEL_CYC = T_DESEL_US * CLK_MHZ;
  localparam int AUTO_CYC = T_AUTO_MS * 1000 * CLK_MHZ;
  localparam int REV_CYC = int'(T_REV_MS * 1000.0 * CLK_MHZ);
  localparam int IDX_CYC = T_IDX_US * CLK_MHZ;
  localparam int DROP_CYC = (T_DROP_NS * CLK_MHZ + 999) / 1000;
  localparam int LOW_CYC = int'(T_LOW_MS * 1000.0 * CLK_MHZ);
  localparam int RECAL_CYC = T_RECAL_MS * 1000 * CLK_MHZ;
  localparam int BLK_W_CYC = T_BLK_W_US * CLK_MHZ;
  localparam int BLK_S_CYC = T_BLK_S_US * CLK_MHZ;
  localparam logic [9:0] TRK_MAX = 10'h27f;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_TRK = 4'h8;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam int ST_RDY = 0;
  localparam int ST_PDONE = 1;
  localparam int ST_OUTER = 2;
  localparam int ST_WFLT = 3;
  localparam int ST_SEL = 4;
  localparam int ST_SEEK = 5;
  localparam int ST_REC = 6;
  localparam int NPIN = 18;
  localparam int P_SEL = 0;
  localparam int P_STEP = 4;
  localparam int P_DIR = 5;
  localparam int P_WG = 6;
  localparam int P_HEAD = 7;
  localparam int P_LOCK = 8;
  localparam int P_INH = 9;
  localparam int P_WCUR = 10;
  localparam int P_SFLT = 11;
  localparam int P_SPIN = 12;
  localparam int P_HOME = 13;
  localparam int P_ONTRK = 14;
  localparam int P_FLUX = 15;
  localparam int P_WDP = 16;
  localparam int P_WDN = 17;
  typedef enum logic [1:0] {
    SK_RECAL = 2'b00,
    SK_IDLE = 2'b01,
    SK_SETTLE = 2'b10
  } ddsdg_seek_e;
  typedef struct packed {
    logic [NPIN-1:0] s1;
    logic [NPIN-1:0] s2;
    ddsdg_seek_e sk;
    logic [9:0] trk;
    logic [CW-1:0] sk_cnt;
    logic [CW-1:0] rev_cnt;
    logic [CW-1:0] dsl_cnt;
    logic [CW-1:0] clr_cnt;
    logic [CW-1:0] blk_cnt;
    logic step_p, we_p, head_p, sel_p, wd_p, pd_p;
    logic homed, ready, pdone, wflt, wg_blk;
    logic [1:0] unit_pos;
    logic wait_n;
    logic [1:0] drv_h;
    logic [31:0] rdata;
    logic o_outer, o_wflt, o_idx, o_rdy, o_pdone, o_sel;
    logic o_rp, o_rn, o_wpls, o_wcur, o_astep, o_ain, o_head;
  } ddsdg_state_s;
endpackage

// file: src/ddsdg_top.sv
// drive-side status, seek timing and flux gating with an avalon register slave
//
// Behaviour
// - track zero flag rises on the step from track one into zero, held there.
// - write fault on write current without gate, or none with gate while chosen.
// - write fault when gating while write disabled, or on gross supply fault.
// - no recording while the write fault flag stands.
// - deselection longer than fifty microseconds clears the write fault.
// - write fault clears itself two milliseconds after all causes are gone.
// - no recording while seeking, or if gate already on when seek completes.
// - index pulse of 128 us once per 16.8 ms revolution.
// - seeks need ready and seek complete (the code also takes steps while seek complete is low); recording also needs on-track heads.
// - not ready blocks recording, seeking and playback output.
// - after power-on ready needs good supplies, speed and heads on zero.
// - ready drops on supply fault or loss of spindle speed.
// - each rise of the write pair records one flux reversal while gated.
// - playback suppressed while recording, seeking or not chosen.
// - playback may be invalid 20 us after recording or head change.
// - if chosen at seek end, playback appears at seek complete.
// - playback may be absent 100 us after reselection.
// - write protect blocks recording, and with the gate sets write fault.
// - drive selected status follows the matching select line.
// - power-on recalibration returns the heads to track zero.
// - status outputs are active only while this unit is chosen.
// - seek complete drops 500 ns after first step, low at least 10 ms.
// - without seek complete: no recording, write fault on attempt, no playback.
//
// Added by the designer: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
module ddsdg_top
  import ddsdg_pkg::*;
#(
  parameter int AUTO_CYC_P = AUTO_CYC,
  parameter int REV_CYC_P = REV_CYC,
  parameter int LOW_CYC_P = LOW_CYC,
  parameter int RECAL_CYC_P = RECAL_CYC
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [3:0] unit_choose_i,
  input wire logic step_i,
  input wire logic direction_in_i,
  input wire logic record_enable_i,
  input wire logic surface_choose_i,
  input wire logic record_lockout_i,
  input wire logic record_inhibit_in_i,
  input wire logic write_current_i,
  input wire logic supply_fault_i,
  input wire logic spindle_ok_i,
  input wire logic home_sense_i,
  input wire logic on_track_i,
  input wire logic head_flux_i,
  input wire logic record_flux_p_i,
  input wire logic record_flux_n_i,
  output logic outer_track_o,
  output logic write_error_o,
  output logic index_o,
  output logic ready_o,
  output logic positioning_done_o,
  output logic unit_chosen_o,
  output logic playback_flux_p_o,
  output logic playback_flux_n_o,
  output logic record_pulse_o,
  output logic write_drive_o,
  output logic act_step_o,
  output logic act_in_o,
  output logic head_sel_o
);

  localparam logic [CW-1:0] C_DESEL = CW'(DESEL_CYC);
  localparam logic [CW-1:0] C_AUTO = CW'(AUTO_CYC_P);
  localparam logic [CW-1:0] C_REV = CW'(REV_CYC_P - 1);
  localparam logic [CW-1:0] C_IDX = CW'(IDX_CYC);
  localparam logic [CW-1:0] C_DROP = CW'(DROP_CYC);
  localparam logic [CW-1:0] C_DONE = CW'(DROP_CYC + LOW_CYC_P);
  localparam logic [CW-1:0] C_RECAL = CW'(RECAL_CYC_P - 1);
  localparam logic [CW-1:0] C_BLK_W = CW'(BLK_W_CYC);
  localparam logic [CW-1:0] C_BLK_S = CW'(BLK_S_CYC);
  localparam logic [CW-1:0] C_ONE = CW'(1);

  function automatic logic pick(input logic [3:0] v, input logic [1:0] p);
    pick = v[p];
  endfunction

  ddsdg_state_s q;
  ddsdg_state_s n;
  logic [NPIN-1:0] pins;
  logic chosen, we, step_rise, cause, rec_ok, pb_ok, seeking, wd;
  logic rd_hit, wr_hit;
  logic [31:0] rsel;

  assign pins = {record_flux_n_i, record_flux_p_i, head_flux_i, on_track_i,
                 home_sense_i, spindle_ok_i, supply_fault_i, write_current_i,
                 record_inhibit_in_i, record_lockout_i, surface_choose_i,
                 record_enable_i, direction_in_i, step_i, unit_choose_i};

  always_comb begin
    n = q;
    n.s1 = pins;
    n.s2 = q.s1;
    // one of four select lines obeyed
    chosen = pick(q.s2[P_SEL+:4], q.unit_pos);
    we = q.s2[P_WG] & chosen;
    seeking = (q.sk != SK_IDLE);
    step_rise = q.s2[P_STEP] & ~q.step_p;
    wd = q.s2[P_WDP] & ~q.s2[P_WDN];
    n.step_p = q.s2[P_STEP];
    n.we_p = we;
    n.head_p = q.s2[P_HEAD];
    n.sel_p = chosen;
    n.wd_p = wd;
    n.pd_p = q.pdone;
    // driver history aligned with the two sync flops on the current sense
    n.drv_h = {q.drv_h[0], q.o_wcur};
    n.o_astep = 1'b0;
    n.o_ain = q.o_ain;

    // ready from supplies, speed and homed heads
    n.ready = q.homed & ~q.s2[P_SFLT] & q.s2[P_SPIN];

    // seek sequencing
    case (q.sk)
      SK_RECAL: begin
        // step outward until the home sensor reports track zero
        if (q.s2[P_HOME]) begin
          n.trk = 10'h000;
          n.homed = 1'b1;
          n.sk = SK_SETTLE;
          n.sk_cnt = C_DROP;
        end else if (q.sk_cnt == C_RECAL) begin
          n.sk_cnt = '0;
          n.o_astep = 1'b1;
          n.o_ain = 1'b0;
        end else begin
          n.sk_cnt = q.sk_cnt + C_ONE;
        end
      end
      SK_IDLE, SK_SETTLE: begin
        // steps taken only when ready and not gated for writing
        if (step_rise && q.ready && chosen && !we) begin
          n.o_astep = 1'b1;
          n.o_ain = q.s2[P_DIR];
          if (q.s2[P_DIR]) begin
            if (q.trk != TRK_MAX) begin
              n.trk = q.trk + 10'h001;
            end
          end else if (q.trk != 10'h000) begin
            n.trk = q.trk - 10'h001;
          end
          if (q.sk == SK_IDLE) begin
            n.sk = SK_SETTLE;
            n.sk_cnt = '0;
          end else if (q.sk_cnt >= C_DROP) begin
            n.sk_cnt = C_DROP + C_ONE;
            n.pdone = 1'b0;
          end else begin
            n.sk_cnt = q.sk_cnt + C_ONE;
          end
        end else if (q.sk == SK_SETTLE) begin
          n.sk_cnt = q.sk_cnt + C_ONE;
          if (q.sk_cnt == C_DROP) begin
            n.pdone = 1'b0;
          end
          if (q.sk_cnt >= C_DONE) begin
            n.pdone = 1'b1;
            n.sk = SK_IDLE;
            n.sk_cnt = '0;
          end
        end
      end
      default: begin
        n.sk = SK_RECAL;
        n.sk_cnt = '0;
      end
    endcase

    // gate already on when seek completes holds recording off
    if (q.pdone && !q.pd_p && we) begin
      n.wg_blk = 1'b1;
    end else if (!we) begin
      n.wg_blk = 1'b0;
    end

    // write fault causes
    cause = (q.s2[P_WCUR] & ~q.s2[P_WG] & ~q.drv_h[1])
          | (~q.s2[P_WCUR] & we & q.drv_h[1])
          | (we & q.s2[P_INH])
          | q.s2[P_SFLT]
          | (we & q.s2[P_LOCK])
          | (we & ~q.pdone);

    // deselection timer
    if (chosen) begin
      n.dsl_cnt = '0;
    end else if (q.dsl_cnt != C_DESEL) begin
      n.dsl_cnt = q.dsl_cnt + C_ONE;
    end
    // quiet timer after causes vanish
    if (cause || !q.wflt) begin
      n.clr_cnt = '0;
    end else if (q.clr_cnt != C_AUTO) begin
      n.clr_cnt = q.clr_cnt + C_ONE;
    end
    // a new cause wins over either clear
    n.wflt = cause | (q.wflt & ~(q.dsl_cnt == C_DESEL) & ~(q.clr_cnt == C_AUTO));

    // recording permission
    rec_ok = we & q.ready & q.pdone & ~seeking & q.s2[P_ONTRK] & ~q.wflt
           & ~q.s2[P_LOCK] & ~q.s2[P_INH] & ~q.wg_blk & ~cause;
    n.o_wcur = rec_ok;
    // one reversal per rise of the write pair
    n.o_wpls = rec_ok & wd & ~q.wd_p;

    // playback blanking after writing, head change or reselection
    if (chosen && !q.sel_p) begin
      n.blk_cnt = C_BLK_S;
    end else if ((q.we_p && !we) || (q.s2[P_HEAD] != q.head_p)) begin
      n.blk_cnt = C_BLK_W;
    end else if (q.blk_cnt != '0) begin
      n.blk_cnt = q.blk_cnt - C_ONE;
    end
    // playback gating, shown at once on seek complete
    pb_ok = chosen & ~we & q.pdone & ~seeking & q.ready & (q.blk_cnt == '0);
    n.o_rp = pb_ok & q.s2[P_FLUX];
    n.o_rn = ~(pb_ok & q.s2[P_FLUX]);

    // revolution counter and index pulse
    if (q.rev_cnt >= C_REV) begin
      n.rev_cnt = '0;
    end else begin
      n.rev_cnt = q.rev_cnt + C_ONE;
    end

    // status outputs enabled by the chosen select line
    n.o_sel = chosen;
    n.o_outer = chosen & (n.trk == 10'h000) & q.homed;
    n.o_wflt = chosen & n.wflt;
    n.o_idx = chosen & (n.rev_cnt < C_IDX);
    n.o_rdy = chosen & n.ready;
    n.o_pdone = chosen & n.pdone;
    n.o_head = q.s2[P_HEAD] & chosen;

    // avalon slave, one wait cycle then answer
    rsel = 32'h0000_0000;
    case (avs_address_i)
      REG_CTRL: rsel[1:0] = q.unit_pos;
      REG_STAT: begin
        rsel[ST_RDY] = q.ready;
        rsel[ST_PDONE] = q.pdone;
        rsel[ST_OUTER] = (q.trk == 10'h000);
        rsel[ST_WFLT] = q.wflt;
        rsel[ST_SEL] = chosen;
        rsel[ST_SEEK] = seeking;
        rsel[ST_REC] = q.o_wcur;
      end
      REG_TRK: rsel[9:0] = q.trk;
      default: rsel = 32'h0000_0000;
    endcase
    rd_hit = avs_read_i & q.wait_n;
    wr_hit = avs_write_i & ~q.wait_n;
    if ((avs_read_i || avs_write_i) && q.wait_n) begin
      n.wait_n = 1'b0;
    end else begin
      n.wait_n = 1'b1;
    end
    if (rd_hit) begin
      n.rdata = rsel;
    end
    if (wr_hit && avs_address_i == REG_CTRL && avs_byteenable_i[0]) begin
      n.unit_pos = avs_writedata_i[1:0];
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      q <= '0;
      q.sk <= SK_RECAL;
      q.unit_pos <= CTRL_RST;
      q.wait_n <= 1'b1;
      q.o_rn <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign avs_readdata_o = q.rdata;
  assign avs_waitrequest_o = q.wait_n;
  assign outer_track_o = q.o_outer;
  assign write_error_o = q.o_wflt;
  assign index_o = q.o_idx;
  assign ready_o = q.o_rdy;
  assign positioning_done_o = q.o_pdone;
  assign unit_chosen_o = q.o_sel;
  assign playback_flux_p_o = q.o_rp;
  assign playback_flux_n_o = q.o_rn;
  assign record_pulse_o = q.o_wpls;
  assign write_drive_o = q.o_wcur;
  assign act_step_o = q.o_astep;
  assign act_in_o = q.o_ain;
  assign head_sel_o = q.o_head;

endmodule

// file: tb/ddsdg_monitor.sv
// assertion checker on the block's pins
`timescale 1ns/1ps
module ddsdg_monitor (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic record_enable_i,
  input wire logic record_lockout_i,
  input wire logic [3:0] unit_choose_i,
  input wire logic outer_track_o,
  input wire logic write_error_o,
  input wire logic index_o,
  input wire logic ready_o,
  input wire logic positioning_done_o,
  input wire logic unit_chosen_o,
  input wire logic playback_flux_p_o,
  input wire logic record_pulse_o,
  input wire logic write_drive_o,
  input wire logic act_step_o,
  input wire logic act_in_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  logic [12:0] ic_q;
  always_ff @(posedge clock_i) ic_q <= index_o ? ic_q + 13'h1 : 13'h0;
  sequence s_lock_gate; record_enable_i && record_lockout_i; endsequence
  sequence s_step_in; act_step_o && act_in_o; endsequence
  property p_lock; s_lock_gate [*5] ##0 unit_chosen_o |-> write_error_o; endproperty
  property p_fblk; write_error_o [*2] |-> !write_drive_o; endproperty
  property p_lblk; record_lockout_i [*4] |-> !write_drive_o; endproperty
  property p_nsel; !unit_chosen_o |-> !(ready_o | outer_track_o | write_error_o | index_o | positioning_done_o); endproperty
  property p_npb; !unit_chosen_o [*2] |-> !playback_flux_p_o; endproperty
  property p_sk; (unit_chosen_o && !positioning_done_o) [*2] |-> !write_drive_o && !playback_flux_p_o; endproperty
  property p_rdy; (unit_chosen_o && !ready_o) [*2] |-> !write_drive_o && !playback_flux_p_o; endproperty
  property p_idx; index_o |-> ic_q < 13'hc80; endproperty
  property p_rec; !record_enable_i [*5] |-> !record_pulse_o; endproperty
  property p_drop; act_step_o |-> ##[10:16] !positioning_done_o; endproperty
  property p_off0; s_step_in |=> !outer_track_o; endproperty
  property p_uc; (unit_choose_i == 4'h0) [*4] |-> !unit_chosen_o; endproperty
  a_lock: assert property (p_lock) else $error("no fault on protected gate");
  a_fblk: assert property (p_fblk) else $error("recording during fault");
  a_lblk: assert property (p_lblk) else $error("recording while protected");
  a_nsel: assert property (p_nsel) else $error("status active while not chosen");
  a_npb: assert property (p_npb) else $error("playback while not chosen");
  a_sk: assert property (p_sk) else $error("activity while seeking");
  a_rdy: assert property (p_rdy) else $error("activity while not ready");
  a_idx: assert property (p_idx) else $error("index pulse too long");
  a_rec: assert property (p_rec) else $error("flux recorded without gate");
  a_drop: assert property (p_drop) else $error("seek complete did not drop");
  a_off0: assert property (p_off0) else $error("track zero flag after inward step");
  a_uc: assert property (p_uc) else $error("chosen without select line");
endmodule

// file: tb/ddsdg_host_model.sv
// formatter side: select lines, step timing and write flux pair
`timescale 1ns/1ps
module ddsdg_host_model (
  input wire logic clock_i,
  input wire logic [3:0] sel_i,
  input wire logic step_req_i,
  input wire logic dir_i,
  input wire logic gate_i,
  output logic [3:0] unit_choose_o = 4'h0,
  output logic step_o = 1'b0,
  output logic direction_o = 1'b0,
  output logic record_enable_o = 1'b0,
  output logic record_flux_p_o = 1'b0,
  output logic record_flux_n_o = 1'b1,
  output int rises_o = 0
);
  logic [2:0] ph_q = 3'h0;
  logic [2:0] fl_q = 3'h0;
  always @(posedge clock_i) begin
    unit_choose_o <= sel_i;
    direction_o <= dir_i;
    record_enable_o <= gate_i;
    step_o <= ph_q > 3'h3;
    if (step_req_i && ph_q == 3'h0) begin
      ph_q <= 3'h6;
    end else if (ph_q != 3'h0) begin
      ph_q <= ph_q - 3'h1;
    end
    fl_q <= record_enable_o ? fl_q + 3'h1 : 3'h0;
    // edges go out on time, no precompensation shift
    record_flux_p_o <= gate_i && record_enable_o && fl_q[2];
    record_flux_n_o <= !(gate_i && record_enable_o && fl_q[2]);
    if (gate_i && record_enable_o && fl_q == 3'h4) begin
      rises_o <= rises_o + 1;
    end
  end
endmodule

// file: tb/tb_top.sv
// testbench for the disk status and flux gating block
`timescale 1ns/1ps
module tb_top;
  localparam int REV = 4000;
  logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, sreq = 1'b0, dir = 1'b0, gate = 1'b0, surf = 1'b0;
  logic lock = 1'b0, inh = 1'b0, sf = 1'b0, spin = 1'b1, home = 1'b0, ontr = 1'b1, hf = 1'b0, wcur, wbad = 1'b0;
  logic [3:0] adr = 4'h0, sel = 4'h0, be = 4'hf, uch;
  logic [31:0] wd = 32'h0, rdat, q, rs = 32'h6566;
  logic wrq, otrk, werr, idx, rdy, pdn, uc, pbp, pbn, rpl, wdrv, stp, dirp, renb, recp, recn, astp, ain, hsel;
  logic [2:0] hs = 3'h0;
  int err_count = 0, checks_done = 0, npl = 0, rises, n, t = 0;
  assign wcur = (wdrv === 1'b1) ^ wbad;
  ddsdg_host_model u_host (.clock_i(clk), .sel_i(sel), .step_req_i(sreq), .dir_i(dir), .gate_i(gate),
    .unit_choose_o(uch), .step_o(stp), .direction_o(dirp), .record_enable_o(renb), .record_flux_p_o(recp),
    .record_flux_n_o(recn), .rises_o(rises));
  ddsdg_top #(.AUTO_CYC_P(3000), .REV_CYC_P(REV), .LOW_CYC_P(100), .RECAL_CYC_P(20)) u_dut (
    .clock_i(clk), .sys_rst_i(rst), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdat), .avs_waitrequest_o(wrq),
    .unit_choose_i(uch), .step_i(stp), .direction_in_i(dirp), .record_enable_i(renb), .surface_choose_i(surf),
    .record_lockout_i(lock), .record_inhibit_in_i(inh), .write_current_i(wcur), .supply_fault_i(sf),
    .spindle_ok_i(spin), .home_sense_i(home), .on_track_i(ontr), .head_flux_i(hf), .record_flux_p_i(recp),
    .record_flux_n_i(recn), .outer_track_o(otrk), .write_error_o(werr), .index_o(idx), .ready_o(rdy),
    .positioning_done_o(pdn), .unit_chosen_o(uc), .playback_flux_p_o(pbp), .playback_flux_n_o(pbn),
    .record_pulse_o(rpl), .write_drive_o(wdrv), .act_step_o(astp), .act_in_o(ain), .head_sel_o(hsel));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  initial begin
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    rs <= xs(rs);
    hf <= rs[0];
    if (rpl === 1'b1) npl <= npl + 1;
  end
  task automatic results;
    if (err_count == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("Error at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    while (wrq !== 1'b0) @(posedge clk);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic step(input logic d);
    dir <= d;
    sreq <= 1'b1;
    cyc(1);
    sreq <= 1'b0;
    t = d ? t + 1 : t - 1;
    cyc(30);
    chk(pdn, 0);
    while (pdn !== 1'b1) @(posedge clk);
    bus(1'b0, 4'h8, 32'h0);
    chk(q, t);
  endtask
  initial begin
    cyc(12);
    rst <= 1'b0;
    cyc(1);
    chk(pbn, 1);
    bus(1'b0, 4'h0, 32'h0);
    chk(q, 0);
    bus(1'b0, 4'hc, 32'h0);
    chk(q, 0);
    sel <= 4'h1;
    cyc(10);
    chk(rdy, 0);
    home <= 1'b1;
    while (pdn !== 1'b1) @(posedge clk);
    chk(rdy, 1);
    chk(otrk, 1);
    n = 2 + int'(rs[1:0]);
    repeat (n) step(1'b1);
    chk(otrk, 0);
    repeat (n) step(1'b0);
    chk(otrk, 1);
    while (idx !== 1'b0) @(posedge clk);
    while (idx !== 1'b1) @(posedge clk);
    n = 0;
    while (idx === 1'b1) begin
      @(posedge clk);
      n++;
    end
    chk(n, 3200);
    while (idx !== 1'b1) begin
      @(posedge clk);
      n++;
    end
    chk(n, REV);
    gate <= 1'b1;
    cyc(60);
    chk(wdrv, 1);
    gate <= 1'b0;
    cyc(10);
    chk(npl, rises);
    chk(werr, 0);
    dir <= 1'b1;
    sreq <= 1'b1;
    cyc(1);
    sreq <= 1'b0;
    cyc(30);
    gate <= 1'b1;
    while (pdn !== 1'b1) @(posedge clk);
    cyc(8);
    chk(wdrv, 0);
    chk(werr, 1);
    lock <= 1'b1;
    cyc(8);
    chk(wdrv, 0);
    lock <= 1'b0;
    gate <= 1'b0;
    cyc(2900);
    chk(werr, 1);
    cyc(200);
    chk(werr, 0);
    spin <= 1'b0;
    cyc(6);
    chk(rdy, 0);
    spin <= 1'b1;
    sf <= 1'b1;
    cyc(6);
    chk(rdy, 0);
    chk(werr, 1);
    sf <= 1'b0;
    sel <= 4'h0;
    cyc(1300);
    chk(otrk | rdy | werr | idx | pdn, 0);
    sel <= 4'h1;
    cyc(6);
    chk(werr, 0);
    inh <= 1'b1;
    gate <= 1'b1;
    cyc(8);
    chk(werr, 1);
    gate <= 1'b0;
    inh <= 1'b0;
    bus(1'b1, 4'h0, 32'h2);
    cyc(6);
    chk(uc, 0);
    sel <= 4'h4;
    cyc(6);
    chk(uc, 1);
    bus(1'b0, 4'h0, 32'h0);
    chk(q, 2);
    cyc(2600);
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      if (i > 2) chk(pbp, hs[2]);
      hs = {hs[1:0], hf};
    end
    surf <= 1'b1;
    cyc(6);
    chk(hsel, 1);
    chk({pbp, pbn}, 2'b01);
    sel <= 4'h0;
    cyc(6);
    chk({pbp, pbn}, 2'b01);
    cyc(1300);
    sel <= 4'h4;
    cyc(6);
    chk(werr, 0);
    wbad <= 1'b1;
    cyc(6);
    chk(werr, 1);
    results();
  end
  initial begin
    cyc(30000);
    err_count++;
    results();
  end
endmodule
bind ddsdg_top ddsdg_monitor u_mon (.clock_i, .sys_rst_i, .record_enable_i, .record_lockout_i, .unit_choose_i,
  .outer_track_o, .write_error_o, .index_o, .ready_o, .positioning_done_o, .unit_chosen_o, .playback_flux_p_o,
  .record_pulse_o, .write_drive_o, .act_step_o, .act_in_o);
